// ===== hw/trq_regs.svh
// request builder and dispatcher constants
// assumes: included by bare name
`ifndef TRQ_REGS_SVH
`define TRQ_REGS_SVH

// ====================
// payload header layout, bit positions inside the first word
`define TRQ_HDR_UNIT_LSB   0
`define TRQ_HDR_THREAD_LSB 16
`define TRQ_HDR_DISP_LSB   32
`define TRQ_HDR_SCRP_LSB   64
`define TRQ_HDR_SCRS_LSB   96
`define TRQ_HDR_BT_LSB     128
`define TRQ_HDR_SMP_LSB    160

// ====================
// scaling of pointers, blocks and scratch
`define TRQ_PTR_SHIFT 6
`define TRQ_BLK_ROUND 9'h00f
`define TRQ_SCR_SHIFT 10

// ====================
// dispatcher control registers, byte offsets and reset values
`define TRQ_OFS_CTRL   4'h0
`define TRQ_OFS_STATUS 4'h4
`define TRQ_OFS_LAST   4'h8
`define TRQ_CTRL_RST   1'b1

`endif

// ===== hw/trq_pkg.sv
// types shared by builder, dispatcher and link
// assumes: compiled before the other files
package trq_pkg;

    // ====================
    // thread control information carried with each request
    typedef struct packed {
        logic [31:0] kernel_addr;
        logic [31:0] bt_addr;
        logic [31:0] smp_addr;
        logic [4:0]  grf_blocks;
        logic        single_flow;
        logic        urgent;
        logic        fp_mode;
        logic [7:0]  exc_mask;
        logic [2:0]  smp_count;
        logic [4:0]  bt_count;
    } trq_ctrl_t;

    // ====================
    // state machines
    typedef enum logic [2:0] {
        TRQ_B_IDLE, TRQ_B_REQ, TRQ_B_BEAT, TRQ_B_RD, TRQ_B_CAP
    } trq_bstate_t;

    typedef enum logic [1:0] {
        TRQ_D_IDLE, TRQ_D_PAY
    } trq_dstate_t;

endpackage : trq_pkg

// ===== hw/trq_link_if.sv
// link between request builder and dispatcher
// assumes: both ends run on the same core_clk
`timescale 1ns/1ns

interface trq_link_if;
    logic               req_valid;
    logic               req_ready;
    trq_pkg::trq_ctrl_t req;
    logic               pl_valid;
    logic               pl_ready;
    logic [6:0]         pl_index;
    logic [255:0]       pl_data;
    logic               pl_last;

    modport builder (
        output req_valid, req, pl_valid, pl_index, pl_data, pl_last,
        input  req_ready, pl_ready
    );

    modport dispatcher (
        input  req_valid, req, pl_valid, pl_index, pl_data, pl_last,
        output req_ready, pl_ready
    );
endinterface : trq_link_if

// ===== hw/trq_builder.sv
// thread request builder: control info plus payload
// assumes: one dispatcher, a data buffer with one-cycle latency,
// and data_start_reg plus data_len kept within 128 registers
//
// Behaviour
// - kernel address is general base plus pointer*64
// - register demand sent as sixteen-register blocks
// - dispatcher only picks units with enough blocks
// - dispatcher maps registers, delivers map to unit
// - urgent requests served before normal, fair within
// - request carries the single-flow flag
// - fp mode seeds control register zero bit
// - exception mask travels with request, unit applies
// - sampler count is only a prefetch hint
// - binding entry count is only a prefetch hint
// - first 256 bits laid out as message header
// - extended header padded up to data start
// - own unit id recognised in message headers
// - thread id unique for a while
// - per-thread scratch region from base and size
// - dispatch index slot, freed on termination
// - binding table is surface base plus pointer*64
// - sampler table is general base plus pointer*64
// - header reports per-thread scratch size
`timescale 1ns/1ns
`include "trq_regs.svh"

module trq_builder #(
    parameter int SLOTS = 8
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    trq_link_if.builder                   link,
    input  wire logic                     spawn,
    output logic                          spawn_ready,
    output logic                          busy,
    input  wire logic [31:0]              kernel_start_ptr,
    input  wire logic [31:0]              general_state_base,
    input  wire logic [31:0]              surface_state_base,
    input  wire logic [31:0]              bt_ptr,
    input  wire logic [31:0]              sampler_ptr,
    input  wire logic [7:0]               grf_demand,
    input  wire logic                     single_flow,
    input  wire logic                     urgent,
    input  wire logic                     fp_mode,
    input  wire logic [7:0]               exc_mask,
    input  wire logic [2:0]               sampler_count,
    input  wire logic [4:0]               bt_count,
    input  wire logic [3:0]               unit_id,
    input  wire logic [31:0]              scratch_base,
    input  wire logic [7:0]               scratch_size_kb,
    input  wire logic [6:0]               data_start_reg,
    input  wire logic [6:0]               data_len,
    output logic                          rd_en,
    output logic [6:0]                    rd_addr,
    input  wire logic [255:0]             rd_data,
    input  wire logic                     term,
    input  wire logic [$clog2(SLOTS)-1:0] term_dispatch_id,
    input  wire logic                     msg_check,
    input  wire logic [3:0]               msg_unit_id,
    output logic                          own_msg
);
    localparam int DW = $clog2(SLOTS);

    trq_pkg::trq_bstate_t state;
    trq_pkg::trq_ctrl_t   ctrl_c;
    logic [SLOTS-1:0]     slots;
    logic [DW-1:0]        free_slot;
    logic                 have_free;
    logic [15:0]          thread_id;
    logic [255:0]         hdr_c;
    logic [6:0]           start_r;
    logic [6:0]           last_idx_r;
    logic [6:0]           start_eff;
    logic [6:0]           nxt_idx;
    logic                 take;

    // ====================
    // helpers
    function automatic logic [31:0] scale64(input logic [31:0] base,
                                            input logic [31:0] ptr);
        return base + (ptr << `TRQ_PTR_SHIFT);
    endfunction : scale64

    function automatic logic [4:0] reg_blocks(input logic [7:0] regs);
        logic [8:0] s;
        s = {1'b0, regs} + `TRQ_BLK_ROUND;
        return s[8:4];
    endfunction : reg_blocks

    assign take      = spawn && spawn_ready;
    assign nxt_idx   = link.pl_index + 7'h01;
    // a zero start would overlap the fixed header, so one is the floor
    assign start_eff = (data_start_reg == 7'h00) ? 7'h01 : data_start_reg;

    // lowest free dispatch slot
    always_comb begin
        free_slot = '0;
        have_free = 1'b0;
        for (int i = SLOTS - 1; i >= 0; i--) begin
            if (!slots[i]) begin
                free_slot = DW'(i);
                have_free = 1'b1;
            end
        end
    end

    // ====================
    // thread control information
    always_comb begin
        ctrl_c = '0;
        ctrl_c.kernel_addr = scale64(general_state_base, kernel_start_ptr);
        ctrl_c.bt_addr     = scale64(surface_state_base, bt_ptr);
        ctrl_c.smp_addr    = scale64(general_state_base, sampler_ptr);
        ctrl_c.grf_blocks  = reg_blocks(grf_demand);
        ctrl_c.single_flow = single_flow;
        ctrl_c.urgent      = urgent;
        ctrl_c.fp_mode     = fp_mode;
        ctrl_c.exc_mask    = exc_mask;
        ctrl_c.smp_count   = sampler_count;
        ctrl_c.bt_count    = bt_count;
    end

    // ====================
    // fixed payload header, one 256-bit register
    // fixed message-header layout
    always_comb begin
        hdr_c = '0;
        hdr_c[`TRQ_HDR_UNIT_LSB +: 4]    = unit_id;
        hdr_c[`TRQ_HDR_THREAD_LSB +: 16] = thread_id;
        hdr_c[`TRQ_HDR_DISP_LSB +: 8]    = 8'(free_slot);
        hdr_c[`TRQ_HDR_SCRP_LSB +: 32]   = 32'(scratch_base + 32'(free_slot)
                                           * (32'(scratch_size_kb) << `TRQ_SCR_SHIFT));
        hdr_c[`TRQ_HDR_SCRS_LSB +: 8]    = scratch_size_kb;
        hdr_c[`TRQ_HDR_BT_LSB +: 32]     = bt_ptr;
        hdr_c[`TRQ_HDR_SMP_LSB +: 32]    = sampler_ptr;
    end

    // ====================
    // dispatch slots: allocation on spawn, release on termination
    // set wins over clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            slots <= '0;
        end else begin
            slots <= (slots & ~(SLOTS'(term) << term_dispatch_id))
                   | (SLOTS'(take) << free_slot);
        end
    end

    // thread ids just count; uniqueness lasts one wrap of 16 bits
    // advance per spawn
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            thread_id <= 16'h0000;
        end else if (take) begin
            thread_id <= thread_id + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            own_msg <= 1'b0;
        end else begin
            own_msg <= msg_check && (msg_unit_id == unit_id);
        end
    end

    // spawn acceptance; a slot freed by term shows one cycle later
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            spawn_ready <= 1'b0;
        end else begin
            spawn_ready <= !take && (state == trq_pkg::TRQ_B_IDLE) && have_free;
        end
    end

    // ====================
    // request and payload sequencer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state          <= trq_pkg::TRQ_B_IDLE;
            busy           <= 1'b0;
            link.req_valid <= 1'b0;
            link.req       <= '0;
            link.pl_valid  <= 1'b0;
            link.pl_index  <= 7'h00;
            link.pl_data   <= '0;
            link.pl_last   <= 1'b0;
            rd_en          <= 1'b0;
            rd_addr        <= 7'h00;
            start_r        <= 7'h00;
            last_idx_r     <= 7'h00;
        end else begin
            unique case (state)
                trq_pkg::TRQ_B_IDLE: begin
                    if (take) begin
                        link.req       <= ctrl_c;
                        link.req_valid <= 1'b1;
                        link.pl_data   <= hdr_c;
                        link.pl_index  <= 7'h00;
                        link.pl_last   <= (start_eff == 7'h01) && (data_len == 7'h00);
                        start_r        <= start_eff;
                        last_idx_r     <= 7'(start_eff + data_len - 7'h01);
                        busy           <= 1'b1;
                        state          <= trq_pkg::TRQ_B_REQ;
                    end
                end
                trq_pkg::TRQ_B_REQ: begin
                    if (link.req_ready) begin
                        link.req_valid <= 1'b0;
                        // header goes to register zero first
                        link.pl_valid  <= 1'b1;
                        state          <= trq_pkg::TRQ_B_BEAT;
                    end
                end
                trq_pkg::TRQ_B_BEAT: begin
                    if (link.pl_ready) begin
                        link.pl_valid <= 1'b0;
                        if (link.pl_last) begin
                            busy  <= 1'b0;
                            state <= trq_pkg::TRQ_B_IDLE;
                        end else if (nxt_idx < start_r) begin
                            link.pl_valid <= 1'b1;
                            link.pl_index <= nxt_idx;
                            link.pl_data  <= '0;
                            link.pl_last  <= (nxt_idx == last_idx_r);
                        end else begin
                            rd_en         <= 1'b1;
                            rd_addr       <= 7'(nxt_idx - start_r);
                            link.pl_index <= nxt_idx;
                            state         <= trq_pkg::TRQ_B_RD;
                        end
                    end
                end
                trq_pkg::TRQ_B_RD: begin
                    rd_en <= 1'b0;
                    state <= trq_pkg::TRQ_B_CAP;
                end
                trq_pkg::TRQ_B_CAP: begin
                    link.pl_valid <= 1'b1;
                    link.pl_data  <= rd_data;
                    link.pl_last  <= (link.pl_index == last_idx_r);
                    state         <= trq_pkg::TRQ_B_BEAT;
                end
            endcase
        end
    end
endmodule : trq_builder

// ===== hw/trq_dispatch.sv
// dispatcher end: picks a unit, maps registers, loads the payload
// assumes: an Avalon-MM master; blocks are handed out bump-style,
// so a unit's released blocks must come back before its base is reused
`timescale 1ns/1ns
`include "trq_regs.svh"

module trq_dispatch #(
    parameter int NUM_EU        = 4,
    parameter int BLOCKS_PER_EU = 8
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    trq_link_if.dispatcher                 link,
    input  wire logic [3:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    output logic [31:0]                    avs_readdata,
    output logic                           avs_waitrequest,
    output logic                           launch_valid,
    output logic [$clog2(NUM_EU)-1:0]      launch_eu,
    output logic [7:0]                     launch_base,
    output trq_pkg::trq_ctrl_t             launch_ctrl,
    output logic                           grf_we,
    output logic [$clog2(NUM_EU)-1:0]      grf_eu,
    output logic [7:0]                     grf_reg,
    output logic [255:0]                   grf_data,
    input  wire logic                      release_valid,
    input  wire logic [$clog2(NUM_EU)-1:0] release_eu,
    input  wire logic [4:0]                release_blocks
);
    localparam int EW = $clog2(NUM_EU);

    trq_pkg::trq_dstate_t state;
    trq_pkg::trq_ctrl_t   urg_c;
    trq_pkg::trq_ctrl_t   norm_c;
    trq_pkg::trq_ctrl_t   sel_c;
    logic                 urg_v;
    logic                 norm_v;
    logic [7:0]           free_blk [NUM_EU];
    logic [EW-1:0]        rr;
    logic [EW-1:0]        pick;
    logic                 found;
    logic                 do_launch;
    logic                 accept;
    logic                 ctrl_en;
    logic [15:0]          launches;

    assign accept    = link.req_valid && link.req_ready;
    assign sel_c     = urg_v ? urg_c : norm_c;
    assign do_launch = (state == trq_pkg::TRQ_D_IDLE) && (urg_v || norm_v) && found;

    // ====================
    // unit search, round-robin start keeps normal traffic fair
    // enough free blocks only
    always_comb begin
        int idx;
        idx   = 0;
        found = 1'b0;
        pick  = '0;
        for (int i = 0; i < NUM_EU; i++) begin
            idx = (int'(rr) + i) % NUM_EU;
            if (!found && (free_blk[idx] >= 8'(sel_c.grf_blocks))) begin
                found = 1'b1;
                pick  = EW'(idx);
            end
        end
    end

    // ====================
    // request intake into one slot per class
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            link.req_ready <= 1'b0;
            urg_v          <= 1'b0;
            norm_v         <= 1'b0;
            urg_c          <= '0;
            norm_c         <= '0;
        end else begin
            // ready waits for a free slot of the request's own class
            link.req_ready <= ctrl_en && link.req_valid && !link.req_ready
                            && !(link.req.urgent ? urg_v : norm_v);
            if (do_launch) begin
                if (urg_v) begin
                    urg_v <= 1'b0;
                end else begin
                    norm_v <= 1'b0;
                end
            end
            if (accept && link.req.urgent) begin
                urg_v <= 1'b1;
                urg_c <= link.req;
            end
            if (accept && !link.req.urgent) begin
                norm_v <= 1'b1;
                norm_c <= link.req;
            end
        end
    end

    // free register blocks per unit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int e = 0; e < NUM_EU; e++) begin
                free_blk[e] <= 8'(BLOCKS_PER_EU);
            end
        end else begin
            for (int e = 0; e < NUM_EU; e++) begin
                free_blk[e] <= free_blk[e]
                    - ((do_launch && pick == EW'(e)) ? 8'(sel_c.grf_blocks) : 8'h00)
                    + ((release_valid && release_eu == EW'(e)) ? 8'(release_blocks) : 8'h00);
            end
        end
    end

    // ====================
    // launch and payload load
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state         <= trq_pkg::TRQ_D_IDLE;
            rr            <= '0;
            launches      <= 16'h0000;
            launch_valid  <= 1'b0;
            launch_eu     <= '0;
            launch_base   <= 8'h00;
            launch_ctrl   <= '0;
            link.pl_ready <= 1'b0;
            grf_we        <= 1'b0;
            grf_eu        <= '0;
            grf_reg       <= 8'h00;
            grf_data      <= '0;
        end else begin
            launch_valid <= 1'b0;
            grf_we       <= 1'b0;
            unique case (state)
                trq_pkg::TRQ_D_IDLE: begin
                    if (do_launch) begin
                        launch_valid  <= 1'b1;
                        launch_eu     <= pick;
                        launch_base   <= 8'(BLOCKS_PER_EU) - free_blk[pick];
                        // fp mode and mask reach the unit
                        launch_ctrl   <= sel_c;
                        rr            <= EW'((int'(pick) + 1) % NUM_EU);
                        launches      <= launches + 16'h0001;
                        link.pl_ready <= 1'b1;
                        state         <= trq_pkg::TRQ_D_PAY;
                    end
                end
                trq_pkg::TRQ_D_PAY: begin
                    if (link.pl_valid) begin
                        grf_we   <= 1'b1;
                        grf_eu   <= launch_eu;
                        grf_reg  <= {launch_base[3:0], 4'h0} + {1'b0, link.pl_index};
                        grf_data <= link.pl_data;
                        if (link.pl_last) begin
                            link.pl_ready <= 1'b0;
                            state         <= trq_pkg::TRQ_D_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ====================
    // Avalon-MM slave: answers on the second edge of a request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
            ctrl_en         <= `TRQ_CTRL_RST;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            unique case (avs_address)
                `TRQ_OFS_CTRL:   avs_readdata <= {31'h00000000, ctrl_en};
                `TRQ_OFS_STATUS: avs_readdata <= {13'h0000, norm_v, urg_v,
                                                  state != trq_pkg::TRQ_D_IDLE, launches};
                `TRQ_OFS_LAST:   avs_readdata <= {16'h0000, launch_base, 8'(launch_eu)};
                default:         avs_readdata <= 32'h00000000;
            endcase
        end else begin
            // write lands on the edge the master sees waitrequest low
            if (avs_write && !avs_waitrequest && avs_address == `TRQ_OFS_CTRL) begin
                ctrl_en <= avs_writedata[0];
            end
            avs_waitrequest <= 1'b1;
        end
    end
endmodule : trq_dispatch

// ===== tb/trq_link_monitor.sv
// link checker: handshake holds and header layout
// assumes: fed the link signals by name, one clock domain
`timescale 1ns/1ns
module trq_link_monitor (
    input wire logic               core_clk,
    input wire logic               rst,
    input wire logic               req_valid,
    input wire logic               req_ready,
    input wire trq_pkg::trq_ctrl_t req,
    input wire logic               pl_valid,
    input wire logic               pl_ready,
    input wire logic [6:0]         pl_index,
    input wire logic [255:0]       pl_data,
    input wire logic               pl_last
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // ====================
    // handshakes: request, beat data and beat index held until taken
    property p_rq; req_valid && !req_ready |=> req_valid && $stable(req); endproperty
    a_rq: assert property (p_rq) else $error("request not held");
    property p_rdy; req_ready |-> req_valid; endproperty
    a_rdy: assert property (p_rdy) else $error("ready without request");
    property p_one; pl_valid |-> !req_valid; endproperty
    a_one: assert property (p_one) else $error("request during payload");
    property p_bt; pl_valid && !pl_ready |=> pl_valid && $stable(pl_data) && $stable(pl_index);
    endproperty
    a_bt: assert property (p_bt) else $error("beat not held");
    // ====================
    // payload order and header layout
    property p_hd; req_valid && req_ready |=> pl_valid && pl_index == 7'h00; endproperty
    a_hd: assert property (p_hd) else $error("header not first");
    property p_end; pl_valid && pl_ready && pl_last |=> !pl_valid; endproperty
    a_end: assert property (p_end) else $error("beat after last");
    property p_z; pl_valid && pl_index == 7'h00 |-> pl_data[255:192] == 64'h0; endproperty
    a_z: assert property (p_z) else $error("header top not zero");
    property p_g; pl_valid && pl_index == 7'h00 |-> pl_data[15:4] == 12'h0; endproperty
    a_g: assert property (p_g) else $error("unit id field dirty");
    c_acc: cover property (req_valid && req_ready);
    c_stall: cover property ((req_valid && !req_ready) [*8]);
    c_last: cover property (pl_valid && pl_ready && pl_last);
endmodule : trq_link_monitor

// ===== tb/test_thread_request_payload_builder.sv
// bench: builder and dispatcher joined by the link
// assumes: blocks given back at launch, rd_data one cycle after rd_en
`timescale 1ns/1ns
module test_thread_request_payload_builder;
    logic core_clk = 1'b0, rst = 1'b1, spawn = 1'b0, term = 1'b0, msg_check = 1'b0;
    logic avs_read = 1'b0, avs_write = 1'b0, release_valid = 1'b0;
    logic sf, urg, fpm, spawn_ready, busy, rd_en, own_msg, avs_waitrequest, launch_valid, grf_we;
    logic [31:0] ksp, gsb, ssb, btp, smp, sb, avs_writedata = '0, avs_readdata, q;
    logic [7:0] dem, exm, kb, launch_base, grf_reg, base;
    logic [6:0] dsr, dlen, rd_addr;
    logic [4:0] btc, release_blocks = '0;
    logic [3:0] uid, mid, avs_address = '0;
    logic [2:0] smc, term_dispatch_id = '0;
    logic [1:0] release_eu = '0, launch_eu, grf_eu;
    logic [255:0] rd_data = '0, grf_data, qd[$], qm[$];
    trq_pkg::trq_ctrl_t launch_ctrl, ec, qc[$];
    int seed = 79625, bad_count = 0, n_compared = 0, k, j, tid = 0;
    trq_link_if link ();
    always #4 core_clk = ~core_clk;
    trq_builder u_trq_builder (.core_clk, .rst, .link(link.builder), .spawn, .spawn_ready, .busy,
        .kernel_start_ptr(ksp), .general_state_base(gsb), .surface_state_base(ssb), .bt_ptr(btp),
        .sampler_ptr(smp), .grf_demand(dem), .single_flow(sf), .urgent(urg), .fp_mode(fpm),
        .exc_mask(exm), .sampler_count(smc), .bt_count(btc), .unit_id(uid), .scratch_base(sb),
        .scratch_size_kb(kb), .data_start_reg(dsr), .data_len(dlen), .rd_en, .rd_addr, .rd_data,
        .term, .term_dispatch_id, .msg_check, .msg_unit_id(mid), .own_msg);
    trq_dispatch u_trq_dispatch (.core_clk, .rst, .link(link.dispatcher), .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .launch_valid,
        .launch_eu, .launch_base, .launch_ctrl, .grf_we, .grf_eu, .grf_reg, .grf_data,
        .release_valid, .release_eu, .release_blocks);
    trq_link_monitor u_trq_link_monitor (.core_clk, .rst, .req_valid(link.req_valid),
        .req_ready(link.req_ready), .req(link.req), .pl_valid(link.pl_valid),
        .pl_ready(link.pl_ready), .pl_index(link.pl_index), .pl_data(link.pl_data),
        .pl_last(link.pl_last));
    // ====================
    // shared tasks
    task chk(input logic [255:0] s, input logic [255:0] e);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("Error %0t saw %h want %h", $time, s, e);
        end
    endtask : chk
    task put(input logic [255:0] d, input logic [255:0] m);
        qd.push_back(d);
        qm.push_back(m);
    endtask : put
    task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge core_clk);
        while (avs_waitrequest) @(posedge core_clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : av
    // random request; expectations noted once taken
    task issue();
        @(posedge core_clk);
        {ksp, gsb, ssb, btp, smp, sb} <= {6{$random(seed)}} ^ {$random(seed), 160'h0};
        {exm, kb, smc, btc, uid, sf, urg, fpm} <= 31'($random(seed));
        dem <= 8'(($random(seed) & 127) + 1);
        dsr <= 7'($random(seed) & 3);
        dlen <= 7'(($random(seed) & 3) + 1);
        spawn <= 1'b1;
        @(posedge core_clk);
        while (!spawn_ready) @(posedge core_clk);
        spawn <= 1'b0;
        ec = '{gsb + (ksp << 6), ssb + (btp << 6), gsb + (smp << 6), 5'((dem + 8'h0f) >> 4),
               sf, urg, fpm, exm, smc, btc};
        qc.push_back(ec);
        put({64'h0, smp, btp, 24'h0, kb, 64'h0, 16'(tid), 12'h0, uid},
            {{160{1'b1}}, 32'h0, {64{1'b1}}});
        for (j = 1; j < dsr; j++) put('0, '1);
        for (j = 0; j < dlen; j++) put({8{gsb ^ j}}, '1);
        tid++;
    endtask : issue
    task fin();
        repeat (2) @(posedge core_clk);
        while (busy) @(posedge core_clk);
    endtask : fin
    task own(input logic [3:0] m);
        @(posedge core_clk);
        mid <= m;
        msg_check <= 1'b1;
        @(posedge core_clk);
        msg_check <= 1'b0;
        @(posedge core_clk);
        chk(256'(own_msg), 256'(m == uid));
    endtask : own
    task results();
        $display("compared %0d errors %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    // buffer answers one cycle after the read, then the lines go stale
    always @(posedge core_clk) begin
        rd_data <= rd_en ? {8{gsb ^ 32'(rd_addr)}} : ~rd_data;
    end
    // watcher: results matched with the oldest note
    always @(posedge core_clk) begin
        release_valid <= launch_valid;
        term <= 1'b0;
        if (launch_valid) begin
            chk(256'(launch_ctrl), 256'(qc.pop_front()));
            base <= launch_base;
            release_eu <= launch_eu;
            release_blocks <= launch_ctrl.grf_blocks;
        end
        if (grf_we) begin
            chk(grf_data & qm.pop_front(), qd.pop_front());
            chk(256'(grf_eu), 256'(release_eu));
            if (grf_reg == 8'(base << 4)) begin
                term <= 1'b1;
                term_dispatch_id <= grf_data[34:32];
                chk(256'(grf_data[95:64]), 256'(sb + grf_data[39:32] * kb * 1024));
            end
        end
    end
    initial begin
        #200000;
        bad_count++;
        results();
    end
    // ====================
    // registers, refused request, then more launches than slots
    initial begin
        {ksp, gsb, ssb, btp, smp, sb, dem, exm, kb, dsr, dlen, btc, uid, mid, smc, sf, urg, fpm} = '0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        av(1'b0, 4'h0, '0);
        chk(256'(q), 256'(1));
        av(1'b1, 4'hc, '1);
        av(1'b0, 4'hc, '0);
        chk(256'(q), '0);
        av(1'b1, 4'h0, '0);
        issue();
        repeat (20) @(posedge core_clk);
        av(1'b0, 4'h4, '0);
        chk(256'(q[15:0]), '0);
        av(1'b1, 4'h0, 32'h1);
        fin();
        own(uid);
        for (k = 0; k < 12; k++) begin
            issue();
            fin();
            own(uid ^ 4'(k & 1));
        end
        av(1'b0, 4'h4, '0);
        chk(256'(q[15:0]), 256'(13));
        chk(256'(qd.size() + qc.size()), '0);
        results();
    end
endmodule : test_thread_request_payload_builder
